/* File: port_boost_and_pin_swap_config.sv */
// Drive boost and data pin swap configuration bank of a four-port hub.
`timescale 1ns/100ps
`default_nettype none
`include "port_boost_consts.svh"

module port_boost_and_pin_swap_config
   import port_boost_pkg::*;
#(
   parameter int PORT_COUNT = `LINE_PORT_COUNT,
   parameter int SYNC_STAGES = `SYNC_STAGE_COUNT
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_rd,
   output logic [7:0] cfg_rdata,
   input wire logic cfg_done,
   output logic cfg_locked,
   output logic [1:0] port1_drive_level,
   output logic [1:0] port2_drive_level,
   output logic [1:0] port3_drive_level,
   output logic [1:0] port4_drive_level,
   input wire logic [PORT_COUNT-1:0] xcvr_pos_out,
   input wire logic [PORT_COUNT-1:0] xcvr_neg_out,
   input wire logic [PORT_COUNT-1:0] xcvr_drive_en,
   output logic [PORT_COUNT-1:0] xcvr_pos_in,
   output logic [PORT_COUNT-1:0] xcvr_neg_in,
   input wire logic [PORT_COUNT-1:0] positive_line_pin_i,
   output logic [PORT_COUNT-1:0] positive_line_pin_o,
   output logic [PORT_COUNT-1:0] positive_line_pin_oe_n,
   input wire logic [PORT_COUNT-1:0] negative_line_pin_i,
   output logic [PORT_COUNT-1:0] negative_line_pin_o,
   output logic [PORT_COUNT-1:0] negative_line_pin_oe_n
);

   // The swap map holds exactly one upstream and four downstream bits.
   if (PORT_COUNT != `LINE_PORT_COUNT) begin : g_bad_ports
      $error("port_boost_and_pin_swap_config serves exactly five ports");
   end

   // The pin inputs are asynchronous, so each needs at least a two-stage
   // synchroniser before any logic may read it.
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("port_boost_and_pin_swap_config needs two synchroniser stages");
   end

   cfg_phase_type phase_q;
   cfg_phase_type phase_d;
   logic [7:0] downstream_drive_boost_q;
   logic [7:0] downstream_drive_boost_d;
   logic [7:0] data_pin_swap_map_q;
   logic [7:0] data_pin_swap_map_d;
   logic [7:0] boost_applied_q;
   logic [7:0] boost_applied_d;
   logic [PORT_COUNT-1:0] line_swap_bitmap_q;
   logic [PORT_COUNT-1:0] line_swap_bitmap_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic wr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration phase. Writes land only while loading; once the loader
   // signals completion the bank locks until reset so that neither drive
   // strength nor line polarity can move under live traffic.
   // A loader that never raises cfg_done leaves every port at the boost-free,
   // unswapped defaults. The trade is that a bank once locked can only be
   // changed again through a reset.
   assign wr_ok = cfg_wr && (phase_q == PHASE_LOADING);

   always_comb begin
      phase_d = phase_q;
      unique case (phase_q)
         PHASE_LOADING: begin
            if (cfg_done) begin
               phase_d = PHASE_RUNNING;
            end
         end
         PHASE_RUNNING: begin
            phase_d = PHASE_RUNNING;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         phase_q <= PHASE_LOADING;
      end else begin
         phase_q <= phase_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Staged registers written by the loader. Reset to zero, the boost-free
   // setting that a loader should normally keep.
   // Writes to any other offset are dropped silently; the bank owns only
   // these two bytes.
   always_comb begin
      downstream_drive_boost_d = downstream_drive_boost_q;
      data_pin_swap_map_d = data_pin_swap_map_q;
      if (wr_ok && (cfg_addr == `BOOST_REG_OFFSET)) begin
         downstream_drive_boost_d = cfg_wdata;
      end
      if (wr_ok && (cfg_addr == `SWAP_REG_OFFSET)) begin
         // Reserved bits 7:5 are not stored and read back as zero.
         // Masking here keeps the stored byte itself free of them.
         data_pin_swap_map_d = cfg_wdata & `SWAP_USED_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         downstream_drive_boost_q <= `BOOST_REG_RESET;
         data_pin_swap_map_q <= `SWAP_REG_RESET;
      end else begin
         downstream_drive_boost_q <= downstream_drive_boost_d;
         data_pin_swap_map_q <= data_pin_swap_map_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Applied copies feeding the transceivers. They load once on the edge that
   // leaves the loading phase and never again, so partial writes during
   // loading are never seen by the ports.
   // A write in the same cycle as cfg_done reaches only the staged register;
   // the applied copy takes the value that stood before that edge, so a
   // loader must finish its writes before it signals completion.
   always_comb begin
      boost_applied_d = boost_applied_q;
      line_swap_bitmap_d = line_swap_bitmap_q;
      if ((phase_q == PHASE_LOADING) && cfg_done) begin
         boost_applied_d = downstream_drive_boost_q;
         line_swap_bitmap_d = data_pin_swap_map_q[PORT_COUNT-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         boost_applied_q <= `BOOST_REG_RESET;
         line_swap_bitmap_q <= '0;
      end else begin
         boost_applied_q <= boost_applied_d;
         line_swap_bitmap_q <= line_swap_bitmap_d;
      end
   end

   // Field split of the applied boost register, all straight from flops.
   // Codes rise from no boost at 00 to the strongest boost at 11; nonzero
   // codes may push signalling past compliance and are the loader's choice.
   // The upstream port has no field here; its boost lives elsewhere.
   assign port4_drive_level = boost_applied_q[`PORT4_LEVEL_LSB +: 2];
   assign port3_drive_level = boost_applied_q[`PORT3_LEVEL_LSB +: 2];
   assign port2_drive_level = boost_applied_q[`PORT2_LEVEL_LSB +: 2];
   assign port1_drive_level = boost_applied_q[`PORT1_LEVEL_LSB +: 2];
   // Lock status is the phase itself, so it needs no flop of its own.
   assign cfg_locked = (phase_q == PHASE_RUNNING);

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data appears the cycle after cfg_rd and holds until the next
   // read. Unmapped offsets answer zero.
   // A read and a write in one cycle return the old value, since the mux
   // looks at the staged register before that edge loads it.
   always_comb begin
      rdata_d = rdata_q;
      if (cfg_rd) begin
         unique case (cfg_addr)
            `BOOST_REG_OFFSET: rdata_d = downstream_drive_boost_q;
            `SWAP_REG_OFFSET: rdata_d = data_pin_swap_map_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign cfg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // One pin swapper per port; index 0 is the upstream port and indices 1 to
   // 4 are downstream ports 1 to 4, matching the swap map bit order.
   // Each pair shares one output enable, as a transceiver never drives one
   // line of a pair on its own.
   for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
      line_swap_mux #(
         .SYNC_STAGES(SYNC_STAGES)
      ) u_swap (
         .ref_clk(ref_clk),
         .resetn(resetn),
         .swap_en(line_swap_bitmap_q[p]),
         .xcvr_pos_out(xcvr_pos_out[p]),
         .xcvr_neg_out(xcvr_neg_out[p]),
         .xcvr_drive_en(xcvr_drive_en[p]),
         .xcvr_pos_in(xcvr_pos_in[p]),
         .xcvr_neg_in(xcvr_neg_in[p]),
         .positive_line_pin_i(positive_line_pin_i[p]),
         .positive_line_pin_o(positive_line_pin_o[p]),
         .positive_line_pin_oe_n(positive_line_pin_oe_n[p]),
         .negative_line_pin_i(negative_line_pin_i[p]),
         .negative_line_pin_o(negative_line_pin_o[p]),
         .negative_line_pin_oe_n(negative_line_pin_oe_n[p])
      );
   end

endmodule : port_boost_and_pin_swap_config

`default_nettype wire

/* File: port_boost_consts.svh */
// Register offsets, field positions and reset values of the boost and swap bank.
`ifndef PORT_BOOST_CONSTS_SVH
`define PORT_BOOST_CONSTS_SVH

`define BOOST_REG_OFFSET 8'hf8
`define SWAP_REG_OFFSET 8'hfa

`define BOOST_REG_RESET 8'h00
`define SWAP_REG_RESET 8'h00

`define PORT4_LEVEL_LSB 6
`define PORT3_LEVEL_LSB 4
`define PORT2_LEVEL_LSB 2
`define PORT1_LEVEL_LSB 0

`define SWAP_UPSTREAM_BIT 0
`define SWAP_USED_MASK 8'h1f

`define LINE_PORT_COUNT 5
`define SYNC_STAGE_COUNT 2

`endif

/* File: port_boost_pkg.sv */
// Types shared by the boost and swap configuration bank.
package port_boost_pkg;

   // Drive strength levels of one port transceiver.
   typedef enum logic [1:0] {
      DRIVE_NORMAL = 2'h0,
      DRIVE_LOW = 2'h1,
      DRIVE_MEDIUM = 2'h2,
      DRIVE_HIGH = 2'h3
   } drive_level_type;

   // Configuration phase of the bank.
   typedef enum logic {
      PHASE_LOADING,
      PHASE_RUNNING
   } cfg_phase_type;

endpackage : port_boost_pkg

/* File: line_swap_mux.sv */
// Per-port exchange of positive and negative data line pin roles.
`timescale 1ns/100ps
`default_nettype none

module line_swap_mux #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic swap_en,
   input wire logic xcvr_pos_out,
   input wire logic xcvr_neg_out,
   input wire logic xcvr_drive_en,
   output logic xcvr_pos_in,
   output logic xcvr_neg_in,
   input wire logic positive_line_pin_i,
   output logic positive_line_pin_o,
   output logic positive_line_pin_oe_n,
   input wire logic negative_line_pin_i,
   output logic negative_line_pin_o,
   output logic negative_line_pin_oe_n
);

   // Fewer than two stages would let a metastable pin value into logic.
   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("line_swap_mux needs at least two synchroniser stages");
   end

   logic [SYNC_STAGES-1:0] pos_sync_q;
   logic [SYNC_STAGES-1:0] pos_sync_d;
   logic [SYNC_STAGES-1:0] neg_sync_q;
   logic [SYNC_STAGES-1:0] neg_sync_d;
   logic pos_pin_o_q;
   logic pos_pin_o_d;
   logic neg_pin_o_q;
   logic neg_pin_o_d;
   logic pin_oe_n_q;
   logic pin_oe_n_d;
   logic pos_in_q;
   logic pos_in_d;
   logic neg_in_q;
   logic neg_in_d;

   ////////////////////////////////////////////////////////////////////////////
   // Next values: only the last synchroniser stage is looked at by the mux.
   always_comb begin
      pos_sync_d = {pos_sync_q[SYNC_STAGES-2:0], positive_line_pin_i};
      neg_sync_d = {neg_sync_q[SYNC_STAGES-2:0], negative_line_pin_i};
      if (swap_en) begin
         pos_pin_o_d = xcvr_neg_out;
         neg_pin_o_d = xcvr_pos_out;
         pos_in_d = neg_sync_q[SYNC_STAGES-1];
         neg_in_d = pos_sync_q[SYNC_STAGES-1];
      end else begin
         pos_pin_o_d = xcvr_pos_out;
         neg_pin_o_d = xcvr_neg_out;
         pos_in_d = pos_sync_q[SYNC_STAGES-1];
         neg_in_d = neg_sync_q[SYNC_STAGES-1];
      end
      pin_oe_n_d = ~xcvr_drive_en; // Both pins of a pair drive together.
   end

   // Registers; pins start released and idle low.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pos_sync_q <= '0;
         neg_sync_q <= '0;
         pos_pin_o_q <= 1'b0;
         neg_pin_o_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
         pos_in_q <= 1'b0;
         neg_in_q <= 1'b0;
      end else begin
         pos_sync_q <= pos_sync_d;
         neg_sync_q <= neg_sync_d;
         pos_pin_o_q <= pos_pin_o_d;
         neg_pin_o_q <= neg_pin_o_d;
         pin_oe_n_q <= pin_oe_n_d;
         pos_in_q <= pos_in_d;
         neg_in_q <= neg_in_d;
      end
   end

   assign positive_line_pin_o = pos_pin_o_q;
   assign negative_line_pin_o = neg_pin_o_q;
   assign positive_line_pin_oe_n = pin_oe_n_q;
   assign negative_line_pin_oe_n = pin_oe_n_q;
   assign xcvr_pos_in = pos_in_q;
   assign xcvr_neg_in = neg_in_q;

endmodule : line_swap_mux

`default_nettype wire

/* File: port_boost_and_pin_swap_config_properties.sv */
// Checker of lock, drive level and pin routing behaviour.
`timescale 1ns/100ps
`default_nettype none
module cfg_checker #(parameter int PORT_COUNT = 5) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cfg_done,
   input wire logic cfg_locked,
   input wire logic [7:0] lv,
   input wire logic [PORT_COUNT-1:0] po,
   input wire logic [PORT_COUNT-1:0] no,
   input wire logic [PORT_COUNT-1:0] de,
   input wire logic [PORT_COUNT-1:0] ppo,
   input wire logic [PORT_COUNT-1:0] npo,
   input wire logic [PORT_COUNT-1:0] poe,
   input wire logic [PORT_COUNT-1:0] noe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////
   // Taking the lock is two steps: done while unlocked, then locked on each of the next two cycles.
   sequence s_take;
      cfg_done && !cfg_locked;
   endsequence
   sequence s_applied;
      cfg_locked ##1 cfg_locked;
   endsequence
   property p_lock_take;
      s_take |=> s_applied;
   endproperty
   a_lock_take: assert property (p_lock_take) else $error("no lock");
   property p_lock_cause;
      $rose(cfg_locked) |-> $past(cfg_done);
   endproperty
   a_lock_cause: assert property (p_lock_cause) else $error("bad lock");
   property p_level_hold;
      cfg_locked |=> $stable(lv);
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level moved");
   property p_level_zero;
      !cfg_locked |-> lv == 8'h00;
   endproperty
   a_level_zero: assert property (p_level_zero) else $error("early level");
   // Enables follow the transceiver one cycle late, common to the pair.
   property p_oe;
      $past(resetn) |-> poe == ~$past(de) && noe == ~$past(de);
   endproperty
   a_oe: assert property (p_oe) else $error("enable wrong");
   property p_straight;
      $past(resetn) && !$past(cfg_locked)
         |-> ppo == $past(po) && npo == $past(no);
   endproperty
   a_straight: assert property (p_straight) else $error("crossed");
   // Once locked, each pair is either straight or fully crossed.
   property p_pair;
      $past(resetn) && $past(cfg_locked) |->
         (((ppo ^ $past(po)) | (npo ^ $past(no)))
         & ((ppo ^ $past(no)) | (npo ^ $past(po)))) == '0;
   endproperty
   a_pair: assert property (p_pair) else $error("pair split");
endmodule : cfg_checker
bind port_boost_and_pin_swap_config cfg_checker #(.PORT_COUNT(PORT_COUNT))
   chk (.ref_clk(ref_clk), .resetn(resetn), .cfg_done(cfg_done),
   .cfg_locked(cfg_locked), .lv({port4_drive_level, port3_drive_level,
   port2_drive_level, port1_drive_level}), .po(xcvr_pos_out),
   .no(xcvr_neg_out), .de(xcvr_drive_en), .ppo(positive_line_pin_o),
   .npo(negative_line_pin_o), .poe(positive_line_pin_oe_n),
   .noe(negative_line_pin_oe_n));
`default_nettype wire

/* File: line_far_end.sv */
// Far end of the data line pairs: pull-downs and a remote driver.
`timescale 1ns/100ps
`default_nettype none
module line_far_end #(parameter int N = 5) (
   input wire logic [N-1:0] po,
   input wire logic [N-1:0] no,
   input wire logic [N-1:0] poe,
   input wire logic [N-1:0] noe,
   input wire logic [N-1:0] fp,
   input wire logic [N-1:0] fn,
   input wire logic [N-1:0] fe,
   output logic [N-1:0] pi,
   output logic [N-1:0] ni
);
   // The hub wins when enabled; a line neither end drives falls to 0 on its pull-down.
   assign pi = (~poe & po) | (poe & fe & fp);
   assign ni = (~noe & no) | (noe & fe & fn);
endmodule : line_far_end
`default_nettype wire

/* File: port_boost_and_pin_swap_config_tb.sv */
// Self-checking bench of the boost and swap configuration bank.
`timescale 1ns/100ps
`default_nettype none
module port_boost_and_pin_swap_config_tb;
   logic ref_clk, resetn, wr, rd, done, locked;
   logic [7:0] addr, wd, rdata, rv;
   logic [1:0] l1, l2, l3, l4;
   logic [4:0] po, no, de, xpi, xni, ppo, npo, poe, noe, fp, fn, fe, pi, ni;
   int failures, tests_run;
   port_boost_and_pin_swap_config dut (.ref_clk(ref_clk), .resetn(resetn),
      .cfg_addr(addr), .cfg_wr(wr), .cfg_wdata(wd), .cfg_rd(rd),
      .cfg_rdata(rdata), .cfg_done(done), .cfg_locked(locked),
      .port1_drive_level(l1), .port2_drive_level(l2),
      .port3_drive_level(l3), .port4_drive_level(l4), .xcvr_pos_out(po),
      .xcvr_neg_out(no), .xcvr_drive_en(de), .xcvr_pos_in(xpi),
      .xcvr_neg_in(xni), .positive_line_pin_i(pi), .positive_line_pin_o(ppo),
      .positive_line_pin_oe_n(poe), .negative_line_pin_i(ni),
      .negative_line_pin_o(npo), .negative_line_pin_oe_n(noe));
   line_far_end far (.po(ppo), .no(npo), .poe(poe), .noe(noe), .fp(fp),
      .fn(fn), .fe(fe), .pi(pi), .ni(ni));
   ////////////////////////////////////////
   // Free-running clock, and a watchdog of 5000 cycles, far beyond the run.
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      #100us;
      failures++;
      stop_test();
   end
   // Inputs change 1 ns after the edge so the edge never races them.
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1;
      step();
      wr = 0;
      // An idle edge, so a following call never lowers and raises at once.
      step();
   endtask : wrt
   task automatic rdr(input logic [7:0] a);
      addr = a;
      rd = 1;
      step();
      rd = 0;
      step();
      rv = rdata;
   endtask : rdr
   task automatic do_reset();
      resetn = 0;
      repeat (12) step();
      resetn = 1;
      chk("locked rst", 8'h00, {7'h0, locked});
      chk("level rst", 8'h00, {l4, l3, l2, l1});
      $display("Reset test done");
   endtask : do_reset
   // Reset values, reserved swap bits and an unmapped offset.
   task automatic t_regs();
      rdr(8'hf8);
      chk("boost rst", 8'h00, rv);
      rdr(8'hfa);
      chk("swap rst", 8'h00, rv);
      wrt(8'hfa, 8'hff);
      rdr(8'hfa);
      chk("swap rsvd", 8'h1f, rv);
      rdr(8'hf9);
      chk("unmapped", 8'h00, rv);
      $display("Register test done");
   endtask : t_regs
   // Lock with a write in the same cycle; only earlier values apply.
   task automatic t_lock(input logic [7:0] b, input logic [7:0] s);
      wrt(8'hf8, b);
      wrt(8'hfa, s);
      rdr(8'hf8);
      chk("boost", b, rv);
      chk("level early", 8'h00, {l4, l3, l2, l1});
      done = 1;
      wrt(8'hf8, ~b);
      done = 0;
      chk("locked", 8'h01, {7'h0, locked});
      chk("levels", b, {l4, l3, l2, l1});
      wrt(8'hf8, 8'h00);
      rdr(8'hf8);
      chk("late write", ~b, rv);
      chk("levels kept", b, {l4, l3, l2, l1});
      $display("Lock test done, boost %h", b);
   endtask : t_lock
   // Both directions through the pins with the given swap map.
   task automatic t_pins(input logic [4:0] sw);
      po = 5'h16;
      no = 5'h0d;
      de = 5'h1f;
      fe = 5'h00;
      step();
      chk("pos pin", {3'h0, (po & ~sw) | (no & sw)}, {3'h0, ppo});
      chk("neg pin", {3'h0, (no & ~sw) | (po & sw)}, {3'h0, npo});
      chk("pos oe", {3'h0, ~de}, {3'h0, poe});
      chk("neg oe", {3'h0, ~de}, {3'h0, noe});
      de = 5'h00;
      fe = 5'h1f;
      fp = 5'h0b;
      fn = 5'h14;
      repeat (4) step();
      chk("pos off", 8'h1f, {3'h0, poe});
      chk("neg off", 8'h1f, {3'h0, noe});
      chk("pos in", {3'h0, (fp & ~sw) | (fn & sw)}, {3'h0, xpi});
      chk("neg in", {3'h0, (fn & ~sw) | (fp & sw)}, {3'h0, xni});
      $display("Pin test done, swap %h", sw);
   endtask : t_pins
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   // Main sequence; the second reset lands in mid-run on a locked bank.
   initial begin
      {resetn, wr, rd, done, addr, wd, po, no, de, fp, fn, fe} = '0;
      failures = 0;
      tests_run = 0;
      do_reset();
      t_regs();
      t_pins(5'h00);
      t_lock(8'he4, 8'h0a);
      t_pins(5'h0a);
      do_reset();
      t_lock(8'h1b, 8'h15);
      t_pins(5'h15);
      stop_test();
   end
endmodule : port_boost_and_pin_swap_config_tb
`default_nettype wire
